// [verilog/rces_pkg.sv]
/*
 remote command error and status package: command codes, error codes,
 register bit positions, reset values, response characters.
 assumes a command decoder upstream that hands over one decoded command per pulse.
*/
package rces_pkg;
    localparam int RCES_CMD_W = 4;
    typedef enum logic [3:0] {
        RCES_CMD_OTHER   = 4'h0,
        RCES_CMD_QUERY   = 4'h1,
        RCES_CMD_CLEAR   = 4'h2,
        RCES_CMD_LOCAL   = 4'h3,
        RCES_CMD_LOCKOUT = 4'h4,
        RCES_CMD_ERR_Q   = 4'h5,
        RCES_CMD_ESR_Q   = 4'h6,
        RCES_CMD_FLAGS_Q = 4'h7,
        RCES_CMD_OPC     = 4'h8,
        RCES_CMD_FLOAT_Q = 4'h9
    } rces_cmd_type;

    typedef enum logic [1:0] {
        RCES_ST_LOCAL   = 2'h0,
        RCES_ST_REMOTE  = 2'h1,
        RCES_ST_LOCKOUT = 2'h2
    } rces_access_type;

    localparam logic [3:0] RCES_ERR_NONE = 4'h0;
    localparam logic [3:0] RCES_ERR_RANGE = 4'h3;
    localparam logic [3:0] RCES_ERR_SYNTAX = 4'h4;
    localparam logic [3:0] RCES_ERR_FIELD_EXP = 4'h5;
    localparam logic [3:0] RCES_ERR_FIELD_UNEXP = 4'h6;
    localparam logic [3:0] RCES_ERR_UNKNOWN = 4'h7;
    localparam logic [3:0] RCES_ERR_TX_OVR = 4'h9;
    localparam logic [3:0] RCES_ERR_RX_OVR = 4'ha;

    localparam int RCES_ESR_ERR_BIT = 0;
    localparam int RCES_ESR_TXOVR_BIT = 1;
    localparam int RCES_ESR_OPC_BIT = 0;
    localparam int RCES_ESR_QUERY_BIT = 3;
    localparam int RCES_ESR_EXEC_BIT = 4;
    localparam int RCES_ESR_CMD_BIT = 5;
    localparam int RCES_ESR_PON_BIT = 7;
    localparam int RCES_FLG_OK_BIT = 0;
    localparam int RCES_FLG_COUNT_BIT = 1;
    localparam int RCES_FLG_SYNTAX_BIT = 2;
    localparam int RCES_FLG_TXOVR_BIT = 4;
    localparam int RCES_FLG_RXOVR_BIT = 5;
    localparam int RCES_FLG_UNKNOWN_BIT = 6;

    localparam logic [3:0] RCES_ERR_RESET = 4'h0;
    localparam logic [7:0] RCES_ESR_RESET = 8'h80;
    localparam logic [7:0] RCES_FLG_RESET = 8'h01;
    localparam logic [7:0] RCES_GPIB_OPC_ANSWER = 8'h01;

    localparam logic [7:0] RCES_CH_PLUS = 8'h2b;
    localparam logic [7:0] RCES_CH_MINUS = 8'h2d;
    localparam logic [7:0] RCES_CH_ZERO = 8'h30;
    localparam logic [7:0] RCES_CH_POINT = 8'h2e;
    localparam logic [7:0] RCES_CH_E = 8'h45;
    localparam logic [7:0] RCES_CH_CR = 8'h0d;
    localparam logic [7:0] RCES_CH_LF = 8'h0a;
    localparam logic [7:0] RCES_CH_COMMA = 8'h2c;
    localparam int RCES_FLOAT_CHARS = 11;
    localparam int RCES_MAX_RESP = 65535;
    localparam logic [3:0] RCES_ZERO_EXP = 4'h9;
endpackage

// [verilog/rces_byte_if.sv]
/*
 byte stream carrier between the response builder and its buffer.
 assumes one clock shared by both ends.
*/
interface rces_byte_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic last;
    modport source (output valid, output data, output last, input ready);
    modport sink (input valid, input data, input last, output ready);
endinterface

// [verilog/rces_skid.sv]
/*
 two-entry buffer on the response byte path.
 assumes valid/ready handshake on both sides, one clock.
*/
module rces_skid #(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    rces_byte_if.sink in_if,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [0:1];
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign in_if.ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign push = in_if.valid && in_if.ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else if (flush) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= {in_if.last, in_if.data};
        end
    end
endmodule

// [verilog/rces_core.sv]
/*
 remote command error/status core: access state, error registers,
 read-and-clear queries, fixed-format float and integer responses.
 assumes an upstream parser giving one decoded command per cmd_valid pulse.
*/
// Behaviour
// R01: float response is sign, six digits with point, E, exponent sign, one digit.
// R02: exponent digit always a multiple of three; mantissa adjusted to match.
// R03: true zero is +0.00000E-9; +0.00000E+0 means value unavailable.
// R04: host sends keyword then required fields, each after a separator.
// R05: field count mismatch reported as field-expected or field-unexpected error.
// R06: interface clear empties registers, flushes transmit data, selects local.
// R07: host should send interface clear at each session start.
// R08: any received command moves the device into the remote state; code does so from local only, except clear and non-gpib local/lockout.
// R09: remote blocks panel configuration changes until panel selects local.
// R10: interface commands execute in local, remote and lockout alike.
// R11: local and lockout commands are invalid when arriving via gpib.
// R12: local re-enables panel changes; lockout disables them, panel cannot unlock.
// R13: error registers accumulate errors; query returns contents then clears.
// R14: error code clears on interface disconnect or lan socket close.
// R15: screen error indication shown while error code is non-zero.
// R16: error code holds highest code 0 to 10; 10 is receive overrun.
// R17: non-gpib event status: bit0 command error, bit1 transmit overrun.
// R18: gpib event status: bit0 opc, 3 query, 4 exec, 5 command, 7 power-on.
// R19: non-gpib flags: bit0 no error, 1 count, 2 syntax/range, 6 unknown, overruns.
// R20: flags query via gpib always answers integer one.
// R21: host should send error queries alone.
// R22: response request before previous response finished raises transmit overrun.
// R23: responses end with cr lf and stay within the maximum length.
// R24: error code updates only when new code is larger.
module rces_core
    import rces_pkg::*;
#(
    parameter int MAX_RESP = RCES_MAX_RESP
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input rces_cmd_type cmd_code,
    input wire logic cmd_gpib,
    input wire logic [3:0] cmd_error,
    input wire logic field_count_bad,
    input wire logic field_missing,
    input wire logic rx_overrun,
    input wire logic exec_error,
    input wire logic link_closed,
    input wire logic gpib_enabled,
    input wire logic float_neg,
    input wire logic float_exp_neg,
    input wire logic [2:0] float_exp_div3,
    input wire logic [19:0] float_mant,
    input wire logic float_zero,
    input wire logic float_unavail,
    input wire logic panel_local_req,
    output logic panel_locked,
    output rces_access_type access_state,
    output logic error_shown,
    output logic abandon_config,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [7:0] tx_data,
    output logic tx_last
);
    rces_byte_if byte_if ();
    logic [3:0] highest_error_code;
    logic [7:0] event_status_flags;
    logic [7:0] legacy_error_flags;
    logic [3:0] eff_error;
    logic [3:0] next_error;
    logic is_clear;
    logic gpib_q;
    logic busy;
    logic [7:0] line [0:12];
    logic [3:0] len;
    logic [3:0] idx;
    logic [15:0] sent;
    logic [7:0] ival;
    logic want_resp;
    logic accept;
    logic out_last_bit;
    logic [8:0] out_word;
    logic resp_cmd;
    logic [7:0] dig_hi;
    logic [7:0] dig_mid;
    logic [7:0] dig_lo;

    assign is_clear = cmd_valid && (cmd_code == RCES_CMD_CLEAR);
    // R05 R11 R22
    always_comb begin
        next_error = cmd_error;
        if (field_count_bad) begin
            next_error = field_missing ? RCES_ERR_FIELD_EXP : RCES_ERR_FIELD_UNEXP;
        end
        if (cmd_gpib && (cmd_code == RCES_CMD_LOCAL || cmd_code == RCES_CMD_LOCKOUT)) begin
            next_error = RCES_ERR_UNKNOWN;
        end
        if (want_resp && busy) begin
            next_error = RCES_ERR_TX_OVR;
        end
        if (rx_overrun) begin
            next_error = RCES_ERR_RX_OVR;
        end
        eff_error = cmd_valid ? next_error : RCES_ERR_NONE;
    end

    // commands that ask for an answer
    always_comb begin
        case (cmd_code)
            RCES_CMD_QUERY, RCES_CMD_ERR_Q, RCES_CMD_ESR_Q: begin
                resp_cmd = 1'b1;
            end
            RCES_CMD_FLAGS_Q, RCES_CMD_FLOAT_Q: begin
                resp_cmd = 1'b1;
            end
            default: begin
                resp_cmd = 1'b0;
            end
        endcase
    end
    assign want_resp = cmd_valid && resp_cmd;
    // answered whatever the access state
    assign accept = want_resp && !busy && (eff_error == RCES_ERR_NONE); // R10

    // access state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            access_state <= RCES_ST_LOCAL;
        end else if (is_clear) begin
            access_state <= RCES_ST_LOCAL; // R06
        end else if (cmd_valid && !cmd_gpib && cmd_code == RCES_CMD_LOCAL) begin
            access_state <= RCES_ST_LOCAL; // R12
        end else if (cmd_valid && !cmd_gpib && cmd_code == RCES_CMD_LOCKOUT) begin
            access_state <= RCES_ST_LOCKOUT; // R12
        end else if (cmd_valid && access_state == RCES_ST_LOCAL) begin
            access_state <= RCES_ST_REMOTE; // R08
        end else if (panel_local_req && access_state == RCES_ST_REMOTE) begin
            access_state <= RCES_ST_LOCAL; // R09
        end
    end
    assign panel_locked = (access_state != RCES_ST_LOCAL); // R09 R12
    assign abandon_config = is_clear; // R06

    // error code register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            highest_error_code <= RCES_ERR_RESET;
        end else if (is_clear || link_closed) begin
            highest_error_code <= RCES_ERR_RESET; // R06 R14
        end else if (eff_error > highest_error_code) begin
            highest_error_code <= eff_error; // R16 R24
        end else if (accept && cmd_code == RCES_CMD_ERR_Q) begin
            highest_error_code <= RCES_ERR_RESET; // R13
        end
    end
    assign error_shown = (highest_error_code != RCES_ERR_NONE); // R15

    // event status register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            event_status_flags <= RCES_ESR_RESET;
            gpib_q <= 1'b0;
        end else begin
            gpib_q <= gpib_enabled;
            if (is_clear || (accept && cmd_code == RCES_CMD_ESR_Q)) begin
                event_status_flags <= 8'h00; // R06 R13
            end
            if (cmd_valid && !cmd_gpib && eff_error != RCES_ERR_NONE) begin
                event_status_flags[RCES_ESR_ERR_BIT] <= 1'b1; // R17
                if (eff_error == RCES_ERR_TX_OVR) begin
                    event_status_flags[RCES_ESR_TXOVR_BIT] <= 1'b1; // R17
                end
            end
            if (cmd_valid && cmd_gpib) begin
                if (cmd_code == RCES_CMD_OPC) begin
                    event_status_flags[RCES_ESR_OPC_BIT] <= 1'b1; // R18
                end
                if (eff_error == RCES_ERR_TX_OVR) begin
                    event_status_flags[RCES_ESR_QUERY_BIT] <= 1'b1; // R18
                end
                if (exec_error || eff_error == RCES_ERR_RANGE) begin
                    event_status_flags[RCES_ESR_EXEC_BIT] <= 1'b1; // R18
                end
                if (eff_error >= RCES_ERR_SYNTAX && eff_error <= RCES_ERR_UNKNOWN) begin
                    event_status_flags[RCES_ESR_CMD_BIT] <= 1'b1; // R18
                end
            end
            if (gpib_enabled && !gpib_q) begin
                event_status_flags[RCES_ESR_PON_BIT] <= 1'b1; // R18
            end
        end
    end

    // legacy flags register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            legacy_error_flags <= RCES_FLG_RESET;
        end else begin
            if (is_clear || (accept && cmd_code == RCES_CMD_FLAGS_Q && !cmd_gpib)) begin
                legacy_error_flags <= RCES_FLG_RESET; // R13
            end
            if (cmd_valid && !cmd_gpib && eff_error != RCES_ERR_NONE) begin
                legacy_error_flags[RCES_FLG_OK_BIT] <= 1'b0; // R19
                case (eff_error)
                    RCES_ERR_FIELD_EXP, RCES_ERR_FIELD_UNEXP:
                        legacy_error_flags[RCES_FLG_COUNT_BIT] <= 1'b1; // R19
                    RCES_ERR_RANGE, RCES_ERR_SYNTAX:
                        legacy_error_flags[RCES_FLG_SYNTAX_BIT] <= 1'b1; // R19
                    RCES_ERR_UNKNOWN:
                        legacy_error_flags[RCES_FLG_UNKNOWN_BIT] <= 1'b1; // R19
                    RCES_ERR_TX_OVR:
                        legacy_error_flags[RCES_FLG_TXOVR_BIT] <= 1'b1; // R19
                    RCES_ERR_RX_OVR:
                        legacy_error_flags[RCES_FLG_RXOVR_BIT] <= 1'b1; // R19
                    default:
                        legacy_error_flags[RCES_FLG_OK_BIT] <= 1'b0;
                endcase
            end
        end
    end

    // integer value to answer
    always_comb begin
        case (cmd_code)
            RCES_CMD_ERR_Q: ival = {4'h0, highest_error_code};
            RCES_CMD_ESR_Q: ival = event_status_flags;
            RCES_CMD_FLAGS_Q: ival = cmd_gpib ? RCES_GPIB_OPC_ANSWER : legacy_error_flags; // R20
            default: ival = 8'h00;
        endcase
    end

    // decimal digits of the integer answer
    assign dig_hi = ival / 8'd100;
    assign dig_mid = (ival / 8'd10) % 8'd10;
    assign dig_lo = ival % 8'd10;

    // response line builder
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            len <= 4'h0;
            idx <= 4'h0;
            sent <= 16'h0000;
            for (int i = 0; i < 13; i++) begin
                line[i] <= 8'h00;
            end
        end else if (is_clear) begin
            busy <= 1'b0; // R06
        end else if (accept) begin
            busy <= 1'b1;
            idx <= 4'h0;
            sent <= 16'h0000;
            if (cmd_code == RCES_CMD_FLOAT_Q) begin
                line[0] <= (float_neg && !float_zero && !float_unavail) ? RCES_CH_MINUS
                    : RCES_CH_PLUS; // R01
                line[1] <= (float_zero || float_unavail) ? RCES_CH_ZERO
                    : RCES_CH_ZERO + {4'h0, float_mant[19:16]};
                line[2] <= RCES_CH_POINT;
                for (int d = 0; d < 4; d++) begin
                    line[3 + d] <= (float_zero || float_unavail) ? RCES_CH_ZERO
                        : RCES_CH_ZERO + {4'h0, float_mant[15 - 4 * d -: 4]};
                end
                line[7] <= RCES_CH_ZERO;
                line[8] <= RCES_CH_E;
                line[9] <= (float_zero || (float_exp_neg && !float_unavail)) ? RCES_CH_MINUS
                    : RCES_CH_PLUS; // R03
                line[10] <= float_unavail ? RCES_CH_ZERO
                    : float_zero ? RCES_CH_ZERO + {4'h0, RCES_ZERO_EXP}
                    : RCES_CH_ZERO + {4'h0, float_exp_div3, 1'b0} + {5'h00, float_exp_div3}; // R02
                line[11] <= RCES_CH_CR; // R23
                line[12] <= RCES_CH_LF; // R23
                len <= 4'd13;
            end else begin
                line[0] <= RCES_CH_ZERO + dig_hi;
                line[1] <= RCES_CH_ZERO + dig_mid;
                line[2] <= RCES_CH_ZERO + dig_lo;
                line[3] <= RCES_CH_CR; // R23
                line[4] <= RCES_CH_LF; // R23
                len <= 4'd5;
            end
        end else if (busy && byte_if.ready) begin
            idx <= idx + 4'h1;
            sent <= sent + 16'h0001;
            if (idx == len - 4'h1 || sent == 16'(MAX_RESP - 1)) begin
                busy <= 1'b0; // R23
            end
        end
    end

    assign byte_if.valid = busy;
    assign byte_if.data = line[idx];
    assign byte_if.last = (idx == len - 4'h1);

    rces_skid #(.WIDTH(9)) u_skid (
        .clk(clk),
        .reset_n(reset_n),
        .flush(is_clear),
        .in_if(byte_if.sink),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(out_word)
    );
    assign tx_data = out_word[7:0];
    assign out_last_bit = out_word[8];
    assign tx_last = out_last_bit && tx_valid;
endmodule

// [tb/rces_core_assertions.sv]
/*
 checker for rces_core: access state, error display, clear and response stream.
 assumes it is bound to rces_core and sees only its ports.
*/
module rces_assertions
    import rces_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input rces_cmd_type cmd_code,
    input wire logic cmd_gpib,
    input wire logic link_closed,
    input wire logic panel_local_req,
    input wire logic panel_locked,
    input rces_access_type access_state,
    input wire logic error_shown,
    input wire logic abandon_config,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_last
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_clear;
        cmd_valid && cmd_code == RCES_CMD_CLEAR;
    endsequence
    sequence s_cr_sent;
        tx_valid && tx_ready && tx_data == RCES_CH_CR ##1 tx_valid;
    endsequence
    property p_clear;
        s_clear |-> abandon_config ##1 (access_state == RCES_ST_LOCAL && !error_shown && !tx_valid);
    endproperty
    a_clear: assert property (p_clear) else $error("clear left state behind");
    property p_locked;
        panel_locked == (access_state != RCES_ST_LOCAL);
    endproperty
    a_locked: assert property (p_locked) else $error("panel lock wrong");
    property p_remote;
        cmd_valid && cmd_code == RCES_CMD_OTHER && access_state != RCES_ST_LOCKOUT
            |=> access_state == RCES_ST_REMOTE;
    endproperty
    a_remote: assert property (p_remote) else $error("command did not go remote");
    property p_lock_hold;
        access_state == RCES_ST_LOCKOUT && panel_local_req && !cmd_valid
            |=> access_state == RCES_ST_LOCKOUT;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("panel left lockout");
    property p_panel_local;
        access_state == RCES_ST_REMOTE && panel_local_req && !cmd_valid
            |=> access_state == RCES_ST_LOCAL;
    endproperty
    a_panel_local: assert property (p_panel_local) else $error("panel local ignored");
    property p_gpib_bad;
        cmd_valid && cmd_gpib && cmd_code inside {RCES_CMD_LOCAL, RCES_CMD_LOCKOUT}
            && access_state != RCES_ST_LOCKOUT |=> error_shown && access_state != RCES_ST_LOCKOUT;
    endproperty
    a_gpib_bad: assert property (p_gpib_bad) else $error("gpib state command accepted");
    property p_link;
        link_closed && !cmd_valid |=> !error_shown;
    endproperty
    a_link: assert property (p_link) else $error("error kept after link close");
    property p_hold;
        tx_valid && !tx_ready && !cmd_valid |=> tx_valid && $stable(tx_data) && $stable(tx_last);
    endproperty
    a_hold: assert property (p_hold) else $error("byte changed while stalled");
    property p_cr_lf;
        s_cr_sent |-> tx_last && tx_data == RCES_CH_LF;
    endproperty
    a_cr_lf: assert property (p_cr_lf) else $error("no line feed after return");
endmodule

bind rces_core rces_assertions u_rces_chk (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_gpib(cmd_gpib), .link_closed(link_closed),
    .panel_local_req(panel_local_req), .panel_locked(panel_locked), .access_state(access_state),
    .error_shown(error_shown), .abandon_config(abandon_config), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

// [tb/rces_host_model.sv]
/*
 host side: drains response bytes with random stalls into a queue.
 assumes the bench raises hold_off to stall completely.
*/
module rces_host_model (
    input wire logic clk,
    input wire logic hold_off,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got[$];
    int seed = 99482;
    initial tx_ready = 1'h0;
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        #2;
        tx_ready = !hold_off && $random(seed) % 4 != 0;
    end
endmodule

// [tb/tb_remote_command_error_status.sv]
/*
 bench for rces_core: reference of error code and access state, checked per command and response.
 assumes rces_pkg, the design and rces_host_model compiled first.
*/
module tb_remote_command_error_status;
    import rces_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
        $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
    logic clk = '0, reset_n = '0, cmd_valid = '0, cmd_gpib = '0, field_count_bad = '0;
    logic field_missing = '0, rx_overrun = '0, exec_error = '0, link_closed = '0;
    logic gpib_enabled = '0, float_neg = '0, float_exp_neg = '0, float_zero = '0;
    logic float_unavail = '0, panel_local_req = '0, hold_off = '0, exp_ovr = '0;
    logic [3:0] cmd_error = '0;
    logic [2:0] float_exp_div3 = '0;
    logic [19:0] float_mant = '0;
    logic [7:0] tx_data, b;
    logic panel_locked, error_shown, abandon_config, tx_valid, tx_ready, tx_last;
    rces_cmd_type cmd_code = RCES_CMD_OTHER;
    rces_access_type access_state, ref_state = RCES_ST_LOCAL;
    int miscompares = 0, samples_checked = 0, seed = 99482, ref_code = 0, k;
    int d[5];
    int fc[4] = '{0, 7, 4, 3};
    int fx[4] = '{2, 64, 4, 4};
    string s;
    always #20 clk = ~clk;
    rces_core DUT (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_gpib(cmd_gpib), .cmd_error(cmd_error), .field_count_bad(field_count_bad),
        .field_missing(field_missing), .rx_overrun(rx_overrun), .exec_error(exec_error),
        .link_closed(link_closed), .gpib_enabled(gpib_enabled), .float_neg(float_neg),
        .float_exp_neg(float_exp_neg), .float_exp_div3(float_exp_div3), .float_mant(float_mant),
        .float_zero(float_zero), .float_unavail(float_unavail), .panel_local_req(panel_local_req),
        .panel_locked(panel_locked), .access_state(access_state), .error_shown(error_shown),
        .abandon_config(abandon_config), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .tx_last(tx_last));
    rces_host_model host (.clk(clk), .hold_off(hold_off), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic pulse(ref logic p);
        @(posedge clk);
        #2;
        p = 1'h1;
        @(posedge clk);
        #2;
        p = 1'h0;
    endtask
    task automatic cmd(rces_cmd_type c, logic g = 1'h0, logic [3:0] e = 4'h0);
        int v;
        v = field_count_bad ? (field_missing ? 5 : 6) : e;
        if (g && (c == RCES_CMD_LOCAL || c == RCES_CMD_LOCKOUT)) v = 7;
        if (exp_ovr) v = 9;
        if (rx_overrun) v = 10;
        @(posedge clk);
        #2;
        cmd_code = c;
        cmd_gpib = g;
        cmd_error = e;
        cmd_valid = 1'h1;
        @(posedge clk);
        #2;
        cmd_valid = 1'h0;
        {field_missing, field_count_bad, rx_overrun, exec_error} = '0;
        if ((c == RCES_CMD_ERR_Q && !exp_ovr) || c == RCES_CMD_CLEAR) ref_code = 0;
        if (v > ref_code) ref_code = v;
        exp_ovr = 1'h0;
        ref_state = c == RCES_CMD_CLEAR ? RCES_ST_LOCAL
            : ref_state == RCES_ST_LOCKOUT ? RCES_ST_LOCKOUT : RCES_ST_REMOTE;
        if (!g && c == RCES_CMD_LOCAL) ref_state = RCES_ST_LOCAL;
        if (!g && c == RCES_CMD_LOCKOUT) ref_state = RCES_ST_LOCKOUT;
        `CHK(access_state, ref_state)
        `CHK(error_shown, ref_code != 0)
    endtask
    task automatic resp(string x);
        x = {x, "\r\n"};
        for (k = 0; k < 400 && host.got.size() < x.len(); k++) @(posedge clk);
        #2;
        if (host.got.size() < x.len()) begin
            miscompares++;
            tally_and_finish();
        end
        for (int i = 0; i < x.len(); i++) begin
            b = host.got.pop_front();
            `CHK(b, x[i])
        end
        `CHK(host.got.size(), 0)
    endtask
    task automatic err_check();
        int v;
        v = ref_code;
        cmd(RCES_CMD_ERR_Q);
        resp($sformatf("%03d", v));
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #2;
        reset_n = 1'h1;
        cmd(RCES_CMD_ESR_Q, 1'h1);
        resp("128");
        cmd(RCES_CMD_FLAGS_Q);
        resp("001");
        cmd(RCES_CMD_QUERY);
        resp("000");
        cmd(RCES_CMD_CLEAR);
        repeat (6) cmd(RCES_CMD_OTHER, 1'h0, 4'(1 + {$random(seed)} % 8));
        err_check();
        err_check();
        field_count_bad = 1'h1;
        cmd(RCES_CMD_OTHER);
        rx_overrun = 1'h1;
        cmd(RCES_CMD_OTHER);
        cmd(RCES_CMD_OTHER, 1'h0, 4'h3);
        err_check();
        cmd(RCES_CMD_OTHER, 1'h0, 4'h4);
        pulse(link_closed);
        ref_code = 0;
        `CHK(error_shown, 1'h0)
        err_check();
        cmd(RCES_CMD_CLEAR);
        foreach (fc[i]) begin
            {field_missing, field_count_bad} = {2{i == 0}};
            cmd(RCES_CMD_OTHER, 1'h0, 4'(fc[i]));
            cmd(RCES_CMD_FLAGS_Q);
            resp($sformatf("%03d", fx[i]));
        end
        cmd(RCES_CMD_FLAGS_Q);
        resp("001");
        cmd(RCES_CMD_ESR_Q);
        resp("001");
        err_check();
        hold_off = 1'h1;
        cmd(RCES_CMD_ERR_Q);
        exp_ovr = 1'h1;
        cmd(RCES_CMD_ERR_Q);
        hold_off = 1'h0;
        resp("000");
        err_check();
        cmd(RCES_CMD_LOCKOUT);
        pulse(panel_local_req);
        `CHK(access_state, RCES_ST_LOCKOUT)
        cmd(RCES_CMD_LOCAL);
        `CHK(panel_locked, 1'h0)
        cmd(RCES_CMD_OTHER);
        pulse(panel_local_req);
        `CHK(access_state, RCES_ST_LOCAL)
        cmd(RCES_CMD_LOCAL, 1'h1);
        cmd(RCES_CMD_LOCKOUT, 1'h1);
        err_check();
        cmd(RCES_CMD_CLEAR);
        gpib_enabled = 1'h1;
        cmd(RCES_CMD_OPC, 1'h1);
        exec_error = 1'h1;
        cmd(RCES_CMD_OTHER, 1'h1, 4'h7);
        cmd(RCES_CMD_ESR_Q, 1'h1);
        resp("177");
        cmd(RCES_CMD_FLAGS_Q, 1'h1);
        resp("001");
        err_check();
        for (int n = 0; n < 6; n++) begin
            float_zero = n == 0;
            float_unavail = n == 1;
            float_neg = n > 1 && $random(seed) % 2 != 0;
            float_exp_neg = $random(seed) % 2 != 0;
            float_exp_div3 = 3'(n % 4);
            for (int j = 0; j < 5; j++) d[j] = {$random(seed)} % 10;
            float_mant = {4'(d[0]), 4'(d[1]), 4'(d[2]), 4'(d[3]), 4'(d[4])};
            cmd(RCES_CMD_FLOAT_Q);
            s = $sformatf("%s%0d.%0d%0d%0d%0d0E%s%0d", float_neg ? "-" : "+", d[0], d[1], d[2],
                d[3], d[4], float_exp_neg ? "-" : "+", 3 * float_exp_div3);
            if (n == 0) s = "+0.00000E-9";
            if (n == 1) s = "+0.00000E+0";
            resp(s);
        end
        hold_off = 1'h1;
        cmd(RCES_CMD_ERR_Q);
        cmd(RCES_CMD_CLEAR);
        hold_off = 1'h0;
        repeat (8) @(posedge clk);
        #2;
        `CHK(host.got.size(), 0)
        tally_and_finish();
    end
endmodule
